// ### tmc_pkg.sv
package tmc_pkg;

  // ==========================================================
  // Register map and layout
  // ==========================================================
  localparam logic [15:0] TMC_ADDR_INST0 = 16'hffba;
  localparam logic [15:0] TMC_ADDR_INST1 = 16'hffb6;
  localparam int TMC_REG_W = 8;
  localparam logic [7:0] TMC_REG_RESET = 8'h00;
  localparam logic [2:0] TMC_MODE_RESET = 3'h0;
  localparam logic [3:0] TMC_HI_ZERO = 4'h0;
  localparam int TMC_OVF_BIT = 0;
  localparam int TMC_EDGE_TOG_BIT = 1;
  localparam int TMC_MODE_MID_BIT = 2;
  localparam int TMC_MODE_HI_BIT = 3;
  localparam int TMC_CNT_W = 16;

  // ==========================================================
  // Valid edge selection codes of the timer input pin
  // ==========================================================
  localparam logic [1:0] TMC_ES_FALL = 2'h0;
  localparam logic [1:0] TMC_ES_RISE = 2'h1;
  localparam logic [1:0] TMC_ES_BOTH = 2'h3;

  // Operating mode, taken from the two upper mode bits
  typedef enum logic [1:0] {
    TMC_STOP,
    TMC_FREE,
    TMC_EDGE_CLR,
    TMC_MATCH_CLR
  } tmc_op_t;

endpackage : tmc_pkg

// ### tmc_edge_if.sv
`timescale 1ns/10ps
interface tmc_edge_if;
  logic valid_edge;
  modport src (output valid_edge);
  modport snk (input valid_edge);
endinterface : tmc_edge_if

// ### tmc_edge_det.sv
`timescale 1ns/10ps
module tmc_edge_det (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin_in,
  input wire logic [1:0] edge_sel,
  tmc_edge_if.src ev
);
  import tmc_pkg::*;

  // ==========================================================
  // Pin synchroniser and edge detection
  // ==========================================================
  logic sync1_q;
  logic sync2_q;
  logic prev_q;
  logic rise;
  logic fall;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= sync2_q;
    end
  end

  assign rise = sync2_q & ~prev_q;
  assign fall = ~sync2_q & prev_q;

  // Edge polarity comes from the prescaler side, not the mode register
  always_comb begin
    unique case (edge_sel)
      TMC_ES_FALL: ev.valid_edge = fall;
      TMC_ES_RISE: ev.valid_edge = rise;
      TMC_ES_BOTH: ev.valid_edge = rise | fall;
      default: ev.valid_edge = 1'b0;
    endcase
  end

  // ==========================================================
  // Checks
  // ==========================================================
  a_edge_polarity:
    assert property (@(posedge clk) disable iff (!rst_n)
      (edge_sel == TMC_ES_RISE && ev.valid_edge) |-> sync2_q && !$past(sync2_q))
    else $error("Rising edge reported without a rising synchronised pin");

endmodule : tmc_edge_det

// ### tmc_mode_control.sv
`timescale 1ns/10ps
module tmc_mode_control #(
  parameter logic [15:0] REG_ADDR = tmc_pkg::TMC_ADDR_INST0,
  parameter int CNT_W = tmc_pkg::TMC_CNT_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_wr_byte,
  input wire logic cpu_wr_bit,
  input wire logic [2:0] cpu_bit_sel,
  input wire logic [tmc_pkg::TMC_REG_W-1:0] cpu_wdata,
  input wire logic cpu_rd,
  output logic [tmc_pkg::TMC_REG_W-1:0] cpu_rdata,
  output logic cpu_hit,
  input wire logic count_en,
  input wire logic timer_input_pin,
  input wire logic [1:0] edge_sel,
  input wire logic [CNT_W-1:0] capcmp_primary,
  input wire logic [CNT_W-1:0] capcmp_secondary,
  input wire logic primary_is_capture,
  input wire logic secondary_is_capture,
  input wire logic primary_capture_trig,
  input wire logic secondary_capture_trig,
  input wire logic oneshot_mode,
  input wire logic oneshot_soft_trigger,
  output logic [CNT_W-1:0] count_value,
  output logic timer_output_pin,
  output logic primary_match_irq,
  output logic secondary_match_irq,
  output logic overflow_flag
);
  import tmc_pkg::*;

  // Refused at elaboration: the all-ones compare and the index math need 2..32 bits
  if (CNT_W < 2 || CNT_W > 32) begin : g_bad_cnt_w
    $error("CNT_W must lie between 2 and 32");
  end

  // ==========================================================
  // State
  // ==========================================================
  logic [2:0] mode_q;
  logic ovf_q;
  logic [CNT_W-1:0] count_q;
  logic tout_q;
  logic pri_irq_q;
  logic sec_irq_q;
  logic [TMC_REG_W-1:0] rdata_q;

  tmc_op_t op;
  logic running;
  logic clr_on_edge;
  logic clr_on_match;
  logic tog_allowed;
  logic valid_edge;
  logic pri_hit;
  logic sec_hit;
  logic pri_cmp_ev;
  logic sec_cmp_ev;
  logic pri_cap_ev;
  logic sec_cap_ev;
  logic edge_clear;
  logic match_clear;
  logic os_clear;
  logic ovf_set;
  logic tog_ev;
  logic addr_hit;
  logic wr_byte_hit;
  logic wr_bit_hit;
  logic ovf_wr;

  // ==========================================================
  // Input edge detection
  // ==========================================================
  tmc_edge_if edge_bus ();

  tmc_edge_det u_edge (
    .clk(clk),
    .rst_n(rst_n),
    .pin_in(timer_input_pin),
    .edge_sel(edge_sel),
    .ev(edge_bus.src)
  );

  assign valid_edge = edge_bus.valid_edge;

  // ==========================================================
  // Mode decode
  // ==========================================================
  assign op = tmc_op_t'(mode_q[TMC_MODE_HI_BIT-1:TMC_MODE_MID_BIT-1]);
  assign running = (op != TMC_STOP);

  always_comb begin
    clr_on_edge = 1'b0;
    clr_on_match = 1'b0;
    tog_allowed = 1'b0;
    unique case (op)
      TMC_STOP: begin
        tog_allowed = 1'b0;
      end
      TMC_FREE: begin
        tog_allowed = 1'b1;
      end
      TMC_EDGE_CLR: begin
        clr_on_edge = 1'b1;
      end
      TMC_MATCH_CLR: begin
        clr_on_match = 1'b1;
        tog_allowed = 1'b1;
      end
    endcase
  end

  // ==========================================================
  // Events
  // ==========================================================
  // Matches are judged on the tick, against the value about to advance
  assign pri_hit = count_en && (count_q == capcmp_primary);
  assign sec_hit = count_en && (count_q == capcmp_secondary);
  assign pri_cmp_ev = running && !primary_is_capture && pri_hit;
  assign sec_cmp_ev = running && !secondary_is_capture && sec_hit;
  assign pri_cap_ev = running && primary_is_capture && primary_capture_trig;
  assign sec_cap_ev = running && secondary_is_capture && secondary_capture_trig;
  assign edge_clear = clr_on_edge && valid_edge;
  assign match_clear = clr_on_match && pri_hit;
  assign os_clear = running && oneshot_mode && oneshot_soft_trigger;
  assign ovf_set = running && count_en && (count_q == '1)
                   && (capcmp_primary == '1);
  assign tog_ev = tog_allowed
                  && (pri_cmp_ev || sec_cmp_ev || (mode_q[0] && valid_edge));

  // ==========================================================
  // Counter
  // ==========================================================
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_q <= '0;
    end else if (!running) begin
      count_q <= '0;
    end else if (edge_clear || match_clear || os_clear) begin
      count_q <= '0;
    end else if (count_en) begin
      count_q <= count_q + 1'b1;
    end
  end

  // ==========================================================
  // Register access
  // ==========================================================
  assign addr_hit = (cpu_addr == REG_ADDR);
  assign wr_byte_hit = cpu_wr_byte && addr_hit;
  assign wr_bit_hit = cpu_wr_bit && addr_hit;
  assign ovf_wr = wr_byte_hit || (wr_bit_hit && cpu_bit_sel == 3'(TMC_OVF_BIT));
  assign cpu_hit = addr_hit && (cpu_rd || cpu_wr_byte || cpu_wr_bit);

  // Mode bits are taken at any time; keeping the timer stopped meanwhile is up to software
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_q <= TMC_MODE_RESET;
    end else if (wr_byte_hit) begin
      mode_q <= cpu_wdata[TMC_MODE_HI_BIT:TMC_EDGE_TOG_BIT];
    end else if (wr_bit_hit) begin
      for (int i = TMC_EDGE_TOG_BIT; i <= TMC_MODE_HI_BIT; i++) begin
        if (cpu_bit_sel == 3'(i)) begin
          mode_q[i-1] <= cpu_wdata[0];
        end
      end
    end
  end

  // Hardware set wins over a software write of zero in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ovf_q <= 1'b0;
    end else if (ovf_set) begin
      ovf_q <= 1'b1;
    end else if (ovf_wr) begin
      ovf_q <= cpu_wdata[0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_q <= TMC_REG_RESET;
    end else if (cpu_rd && addr_hit) begin
      rdata_q <= {TMC_HI_ZERO, mode_q, ovf_q};
    end else begin
      rdata_q <= TMC_REG_RESET;
    end
  end

  // ==========================================================
  // Timer output and interrupt requests
  // ==========================================================
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tout_q <= 1'b0;
    end else if (tog_ev) begin
      tout_q <= ~tout_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pri_irq_q <= 1'b0;
      sec_irq_q <= 1'b0;
    end else begin
      pri_irq_q <= pri_cmp_ev || pri_cap_ev;
      sec_irq_q <= sec_cmp_ev || sec_cap_ev;
    end
  end

  assign cpu_rdata = rdata_q;
  assign count_value = count_q;
  assign timer_output_pin = tout_q;
  assign primary_match_irq = pri_irq_q;
  assign secondary_match_irq = sec_irq_q;
  assign overflow_flag = ovf_q;

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_reset_clear:
    assert property (disable iff (1'b0) !rst_n |=> mode_q == TMC_MODE_RESET && !ovf_q
                     && count_q == '0)
    else $error("Reset did not clear the mode register");

  a_start_count:
    assert property ((wr_byte_hit && !running && cpu_wdata[TMC_MODE_HI_BIT:TMC_MODE_MID_BIT] != 2'h0
                     && !cpu_wr_bit) |=> running)
    else $error("Counter did not start when upper mode bits were written");

  a_stop_hold:
    assert property (!running [*2] |-> count_q == '0 && $stable(tout_q)
                     && !pri_irq_q && !sec_irq_q)
    else $error("Stopped timer counted, toggled or interrupted");

  a_free_run:
    assert property ((op == TMC_FREE && count_en && !os_clear && !wr_byte_hit && !wr_bit_hit)
                     |=> count_q == $past(count_q) + 1'b1)
    else $error("Free-running counter did not advance by one");

  a_edge_clear:
    assert property ((op == TMC_EDGE_CLR && valid_edge) |=> count_q == '0)
    else $error("Valid edge did not clear the counter");

  a_match_clear:
    assert property ((op == TMC_MATCH_CLR && pri_hit) |=> count_q == '0)
    else $error("Primary match did not clear the counter");

  a_toggle_match:
    assert property ((running && op != TMC_EDGE_CLR && pri_cmp_ev)
                     |=> tout_q != $past(tout_q))
    else $error("Timer output missed a toggle on compare match");

  a_toggle_edge:
    assert property ((mode_q[0] && op == TMC_FREE && valid_edge)
                     |=> tout_q != $past(tout_q))
    else $error("Timer output missed a toggle on input edge");

  a_cmp_irq:
    assert property ((running && !secondary_is_capture && sec_hit) |=> secondary_match_irq)
    else $error("Compare match raised no interrupt");

  a_cap_irq:
    assert property ((running && primary_is_capture && primary_capture_trig)
                     |=> primary_match_irq)
    else $error("Capture trigger raised no interrupt");

  a_ovf_set:
    assert property (ovf_set |=> overflow_flag ##1 (overflow_flag || $past(ovf_wr)))
    else $error("Overflow flag not set on all-ones wrap");

  a_ovf_write:
    assert property ((ovf_wr && !ovf_set && !cpu_wdata[0]) |=> !overflow_flag)
    else $error("Software write did not clear the overflow flag");

  a_upper_zero:
    assert property (cpu_rdata[TMC_REG_W-1:TMC_MODE_HI_BIT+1] == TMC_HI_ZERO)
    else $error("Upper register bits read nonzero");

  a_oneshot_clear:
    assert property (os_clear |=> count_q == '0)
    else $error("One-shot trigger did not clear the counter");

  c_free_wrap: cover property (op == TMC_FREE && count_en && count_q == '1);
  c_edge_clear: cover property (edge_clear);
  c_match_clear: cover property (match_clear);
  c_ovf_set: cover property (ovf_set ##1 overflow_flag);

endmodule : tmc_mode_control

// ### test_timer16_mode_control.sv
`timescale 1ns/10ps
module test_timer16_mode_control;
  import tmc_pkg::*;
  // ==========================================================
  // Bench signals; a narrow counter keeps wrap-around reachable
  // ==========================================================
  localparam int CW = 8;
  localparam logic [CW-1:0] ONES = '1;
  logic clk, rst_n, cpu_wr_byte, cpu_wr_bit, cpu_rd, count_en, pin;
  logic [15:0] cpu_addr;
  logic [2:0] cpu_bit_sel;
  logic [7:0] cpu_wdata, cpu_rdata;
  logic cpu_hit, timer_output_pin, primary_match_irq, secondary_match_irq, overflow_flag;
  logic [1:0] edge_sel;
  logic [CW-1:0] capcmp_primary, capcmp_secondary, count_value;
  logic primary_is_capture, secondary_is_capture, primary_capture_trig, secondary_capture_trig;
  logic oneshot_mode, oneshot_soft_trigger, chk_on, rnd_on;
  logic [7:0] m_reg, m_rd;
  logic [CW-1:0] m_cnt;
  logic m_tog, m_ip, m_is, m_ve, s1, s2, s3, hit_e;
  int err_total, check_count, cyc_n, seed, m, e;
  logic [31:0] r, q;

  tmc_mode_control #(.REG_ADDR(TMC_ADDR_INST0), .CNT_W(CW)) u_tmc_mode_control (
    .clk(clk), .rst_n(rst_n), .cpu_addr(cpu_addr), .cpu_wr_byte(cpu_wr_byte),
    .cpu_wr_bit(cpu_wr_bit), .cpu_bit_sel(cpu_bit_sel), .cpu_wdata(cpu_wdata),
    .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata), .cpu_hit(cpu_hit), .count_en(count_en),
    .timer_input_pin(pin), .edge_sel(edge_sel), .capcmp_primary(capcmp_primary),
    .capcmp_secondary(capcmp_secondary), .primary_is_capture(primary_is_capture),
    .secondary_is_capture(secondary_is_capture), .primary_capture_trig(primary_capture_trig),
    .secondary_capture_trig(secondary_capture_trig), .oneshot_mode(oneshot_mode),
    .oneshot_soft_trigger(oneshot_soft_trigger), .count_value(count_value),
    .timer_output_pin(timer_output_pin), .primary_match_irq(primary_match_irq),
    .secondary_match_irq(secondary_match_irq), .overflow_flag(overflow_flag)
  );

  initial clk = 1'b0;
  always #4 clk = ~clk;

  // ==========================================================
  // Reference model, updated on the same edge as the design
  // ==========================================================
  function automatic logic edge_hit(input logic [1:0] es, input logic now, input logic old);
    case (es)
      TMC_ES_FALL: return old & !now;
      TMC_ES_RISE: return now & !old;
      TMC_ES_BOTH: return now ^ old;
      default: return 1'b0;
    endcase
  endfunction : edge_hit

  assign hit_e = (cpu_wr_byte | cpu_wr_bit | cpu_rd) && (cpu_addr == TMC_ADDR_INST0);
  // Valid edge is judged straight off the second sync stage and its delayed copy
  assign m_ve = edge_hit(edge_sel, s2, s3);

  always @(posedge clk) begin
    logic run, mp, ms, clr;
    logic [1:0] md;
    logic [7:0] nxt;
    md = m_reg[3:2];
    run = md != 2'h0;
    mp = run & count_en & (m_cnt == capcmp_primary);
    ms = run & count_en & (m_cnt == capcmp_secondary);
    clr = (md == 2'h2 & m_ve) | (md == 2'h3 & mp) | (oneshot_mode & oneshot_soft_trigger);
    nxt = m_reg;
    if (hit_e & cpu_wr_byte) begin
      nxt = {4'h0, cpu_wdata[3:0]};
    end else if (hit_e & cpu_wr_bit & (cpu_bit_sel < 3'h4)) begin
      nxt[cpu_bit_sel] = cpu_wdata[0];
    end
    if (run & count_en & (m_cnt == ONES) & (capcmp_primary == ONES)) begin
      nxt[0] = 1'b1;
    end
    if (!rst_n) begin
      {m_reg, m_rd, m_cnt, m_tog, m_ip, m_is, s1, s2, s3} <= '0;
    end else begin
      m_reg <= nxt;
      m_ip <= run & (primary_is_capture ? primary_capture_trig : mp);
      m_is <= run & (secondary_is_capture ? secondary_capture_trig : ms);
      if (run & md[0] & ((mp & !primary_is_capture) | (ms & !secondary_is_capture)
          | (m_reg[1] & m_ve))) begin
        m_tog <= ~m_tog;
      end
      m_cnt <= (!run | clr) ? '0 : count_en ? m_cnt + 1'b1 : m_cnt;
      m_rd <= (cpu_rd & hit_e) ? m_reg : 8'h00;
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // ==========================================================
  // Checks and drivers
  // ==========================================================
  task automatic chk(input logic [15:0] g, input logic [15:0] x);
    check_count++;
    if (g !== x) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk

  // One cycle: compare settled outputs, then drive bus op and random inputs
  task automatic tick(input logic [1:0] op, input logic [15:0] a, input logic [7:0] d,
                      input logic [2:0] bs);
    @(negedge clk);
    if (chk_on) begin
      chk(16'(count_value), 16'(m_cnt));
      chk(16'(timer_output_pin), 16'(m_tog));
      chk(16'({primary_match_irq, secondary_match_irq}), 16'({m_ip, m_is}));
      chk(16'(overflow_flag), 16'(m_reg[0]));
      chk(16'(cpu_rdata), 16'(m_rd));
      chk(16'(cpu_hit), 16'(hit_e));
    end
    cpu_wr_byte = (op == 2'h1);
    cpu_wr_bit = (op == 2'h2);
    cpu_rd = (op == 2'h3);
    cpu_addr = a;
    cpu_wdata = d;
    cpu_bit_sel = bs;
    if (rnd_on) begin
      q = $random(seed);
      count_en = q[2:0] != 3'h0;
      if (q[7:4] == 4'h0) pin = ~pin;
      primary_capture_trig = q[12:8] == 5'h1;
      secondary_capture_trig = q[17:13] == 5'h2;
      oneshot_soft_trigger = q[23:18] == 6'h3;
    end
  endtask : tick

  task automatic results;
    if (err_total == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results

  // Ceiling well above the ~9700 cycles of the sequence
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 12000) begin
      err_total++;
      results();
    end
  end

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    seed = 87064;
    {err_total, check_count, cyc_n} = '0;
    {rst_n, chk_on, rnd_on, cpu_wr_byte, cpu_wr_bit, cpu_rd, count_en, pin} = '0;
    {cpu_addr, cpu_bit_sel, cpu_wdata, edge_sel} = '0;
    {capcmp_primary, capcmp_secondary, primary_is_capture, secondary_is_capture} = '0;
    {primary_capture_trig, secondary_capture_trig, oneshot_mode, oneshot_soft_trigger} = '0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    chk_on = 1'b1;
    tick(2'h3, TMC_ADDR_INST0, 8'h00, 3'h0);
    count_en = 1'b1;
    for (int b = 0; b < 8; b++) begin
      if (b < 2 || b > 3) tick(2'h2, TMC_ADDR_INST0, 8'h01, 3'(b));
    end
    tick(2'h3, TMC_ADDR_INST0, 8'h00, 3'h0);
    tick(2'h1, TMC_ADDR_INST0, 8'hf1, 3'h0);
    tick(2'h3, TMC_ADDR_INST0, 8'h00, 3'h0);
    tick(2'h1, TMC_ADDR_INST1, 8'h0c, 3'h0);
    tick(2'h2, TMC_ADDR_INST0, 8'h01, 3'h2);
    repeat (6) tick(2'h0, 16'h0000, 8'h00, 3'h0);
    tick(2'h2, TMC_ADDR_INST0, 8'h00, 3'h2);
    repeat (4) tick(2'h0, 16'h0000, 8'h00, 3'h0);
    rnd_on = 1'b1;
    for (m = 0; m < 8; m++) begin
      for (e = 0; e < 4; e++) begin
        tick(2'h1, TMC_ADDR_INST0, 8'h00, 3'h0);
        r = $random(seed);
        edge_sel = 2'(e);
        capcmp_primary = (e == 0) ? ONES : (r[7:0] | 8'h01);
        capcmp_secondary = r[15:8];
        primary_is_capture = r[16] & (m < 6);
        secondary_is_capture = r[17];
        oneshot_mode = r[18] & (e != 0);
        tick(2'h1, TMC_ADDR_INST0, {r[23:20], 3'(m), 1'b0}, 3'h0);
        repeat (300) begin
          r = $random(seed);
          case (r[4:0])
            5'h0: tick(2'h3, TMC_ADDR_INST0, 8'h00, 3'h0);
            5'h1: tick(2'h3, TMC_ADDR_INST1, 8'h00, 3'h0);
            5'h2: tick(2'h1, TMC_ADDR_INST1, r[15:8], 3'h0);
            5'h3: tick(2'h2, TMC_ADDR_INST0, 8'(r[16]), 3'h0);
            default: tick(2'h0, 16'h0000, 8'h00, 3'h0);
          endcase
        end
      end
    end
    tick(2'h0, 16'h0000, 8'h00, 3'h0);
    results();
  end
endmodule : test_timer16_mode_control
